// file: rtl/bms_params.svh
// constants for the converter sequencer
`ifndef BMS_PARAMS_SVH
`define BMS_PARAMS_SVH
`define BMS_CLK_HZ        20000000
`define BMS_FSW_HZ        400000
`define BMS_SPREAD_PCT    2
`define BMS_LFSR_W        23
`define BMS_LFSR_TAP      18
`define BMS_LFSR_SEED     23'h00_0001
`define BMS_REPEAT_MHZ    1500
`define BMS_SS_TIME_US    3500
`define BMS_SS2_TIME_US   5500
`define BMS_HIC_WAIT_US   5500
`define BMS_HIC_CYCLES    128
`define BMS_SYNC_QUAL     2048
`define BMS_SYNC_MIN_CYC  9
`define BMS_SYNC_MAX_CYC  100
`define BMS_BLANK_NS      100
`define BMS_REF_FULL      10'h3e8
`define BMS_REF_UP_DIV    11'h064
`define BMS_REG_CTRL      8'h00
`define BMS_REG_STATUS    8'h04
`define BMS_REG_REF       8'h08
`define BMS_REG_DITHER    8'h0c
`define BMS_CTRL_EN       0
`define BMS_CTRL_SPREAD   1
`define BMS_CTRL_FORCED_PULSE_WIDTH_MODE     2
`define BMS_CTRL_RST      3'h3
`endif

// file: rtl/bms_pkg.sv
// types for the converter sequencer
package bms_pkg;
    typedef enum logic [4:0] {
        st_off   = 5'b00001,
        st_ss    = 5'b00010,
        st_run   = 5'b00100,
        st_rec   = 5'b01000,
        st_hic   = 5'b10000
    } bms_state_t;
endpackage

// file: rtl/bms_dither.sv
// pseudo-random frequency offset generator with bounded step
`timescale 1ns/100ps
`include "bms_params.svh"
module bms_dither #(
    parameter int W    = `BMS_LFSR_W,
    parameter int TAP  = `BMS_LFSR_TAP,
    parameter int SPAN = 1
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              step,
    input  wire logic              en,
    output logic signed [3:0]      offset
);
    logic [W-1:0] lfsr;

    if (SPAN < 1 || SPAN > 7 || TAP >= W || TAP < 1) begin : g_chk
        $error("bms_dither: bad SPAN or TAP");
    end

    // one shift per switching cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lfsr <= W'(`BMS_LFSR_SEED);
        end else if (step) begin
            lfsr <= {lfsr[W-2:0], lfsr[W-1] ^ lfsr[TAP-1]};
        end
    end

    // random walk of one step per cycle, clipped to the span
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            offset <= 4'sh0;
        end else if (!en) begin
            offset <= 4'sh0;
        end else if (step) begin
            if (lfsr[0] && offset < 4'(SPAN)) begin
                offset <= offset + 4'sh1;
            end else if (!lfsr[0] && offset > 4'(-SPAN)) begin
                offset <= offset - 4'sh1;
            end
        end
    end
endmodule

// file: rtl/bms_sequencer.sv
// switching sequencer: boot recharge, dither, soft start, limits, hiccup
// Summary of operation
// - low boot voltage: low-side recharge before high-side
// - dither spans plus or minus two percent
// - shift-register hop, one step per cycle
// - pattern repeats slower than 1.5 Hz
// - slowed or locked clock stops dithering
// - forced pulse width mode keeps dithering at zero load
// - soft start on uvlo, enable, hiccup, thermal
// - reference ramps over the soft start time
// - soft start forces diode emulation
// - forced mode waits for regulation or timeout, hiccup for the timeout
// - output sag: reference one percent above, ramp
// - recovery hiccup only below 0.4 of set point
// - forced mode allowed during recovery
// - high-side compare after blanking against lesser limit
// - low-side over limit extends the cycle
// - high-side restart only after full period
// - 128 qualified cycles trip hiccup
// - hiccup stops, waits, then soft starts
// - sync locks after 2048 edges, stops dither
// - locked clock forces forced pulse width mode
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`include "bms_params.svh"
module bms_sequencer import bms_pkg::*; #(
    parameter int PERIOD   = `BMS_CLK_HZ / `BMS_FSW_HZ,
    parameter int SS_CYC   = `BMS_SS_TIME_US * (`BMS_CLK_HZ / 1000000),
    parameter int SS2_CYC  = `BMS_SS2_TIME_US * (`BMS_CLK_HZ / 1000000),
    parameter int WAIT_CYC = `BMS_HIC_WAIT_US * (`BMS_CLK_HZ / 1000000),
    parameter int LFSR_W   = `BMS_LFSR_W
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        en_pin,
    input  wire logic        uvlo_ok,
    input  wire logic        otp_flag,
    input  wire logic        sync_pin,
    input  wire logic        boot_uvlo,
    input  wire logic        hs_lim_fixed,
    input  wire logic        hs_lim_loop,
    input  wire logic        ls_over_limit,
    input  wire logic        ls_zero_cross,
    input  wire logic        vout_low,
    input  wire logic        vout_below_40,
    input  wire logic        vout_in_reg,
    input  wire logic        dropout_minoff,
    input  wire logic        slow_light_load,
    input  wire logic        slow_min_on,
    input  wire logic [9:0]  vout_code,
    output logic             hs_gate,
    output logic             ls_gate,
    output logic [9:0]       ref_code,
    output logic             diode_emulation,
    output logic             forced_pulse_width_mode_active,
    output logic             dither_active,
    output logic             hiccup_active,
    output logic             sync_locked
);
    localparam int NS       = 15;
    localparam int SPAN     = PERIOD * `BMS_SPREAD_PCT / 100;
    localparam int BLANK    = (`BMS_BLANK_NS * (`BMS_CLK_HZ / 1000000) + 999) / 1000;
    localparam int RAMP_DIV = SS_CYC / int'(`BMS_REF_FULL);
    localparam int TW       = 20;

    if (PERIOD < `BMS_SYNC_MIN_CYC || PERIOD > 255 || SPAN < 1 || SPAN > 7
        || RAMP_DIV < 1 || SS_CYC >= 2**TW || SS2_CYC >= 2**TW
        || WAIT_CYC < 1 || WAIT_CYC >= 2**TW || BLANK >= PERIOD) begin : g_chk
        $error("bms_sequencer: parameters out of range");
    end
    // repetition of the whole pattern must be slower than the audio floor
    if (longint'(2**LFSR_W - 1) * longint'(`BMS_REPEAT_MHZ)
        <= longint'(`BMS_CLK_HZ / PERIOD) * 1000) begin : g_rep
        $error("bms_sequencer: pattern repeats too fast");
    end

    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == `BMS_REG_CTRL) || (a == `BMS_REG_STATUS)
                || (a == `BMS_REG_REF) || (a == `BMS_REG_DITHER);
    endfunction

    // two-stage synchronisers for every one-bit analog or pin input; vout_code is used unsynchronised
    logic [NS-1:0] raw;
    logic [NS-1:0] s1;
    logic [NS-1:0] s2;
    assign raw = {en_pin, uvlo_ok, otp_flag, sync_pin, boot_uvlo, hs_lim_fixed,
                  hs_lim_loop, ls_over_limit, ls_zero_cross, vout_low,
                  vout_below_40, vout_in_reg, dropout_minoff, slow_light_load,
                  slow_min_on};
    for (genvar g = 0; g < NS; g++) begin : g_sync
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                s1[g] <= 1'b0;
                s2[g] <= 1'b0;
            end else begin
                s1[g] <= raw[g];
                s2[g] <= s1[g];
            end
        end
    end

    logic en_s, uvlo_s, otp_s, sync_s, boot_s, hsf_s, hsl_s, lso_s, lsz_s;
    logic vlow_s, v40_s, vreg_s, dmin_s, sll_s, smo_s;
    assign {en_s, uvlo_s, otp_s, sync_s, boot_s, hsf_s, hsl_s, lso_s, lsz_s,
            vlow_s, v40_s, vreg_s, dmin_s, sll_s, smo_s} = s2;

    bms_state_t        state;
    bms_state_t        next_state;
    logic [2:0]        ctrl;
    logic [7:0]        cyc_cnt;
    logic [7:0]        cyc_len;
    logic signed [3:0] dither_off;
    logic [7:0]        sync_int;
    logic [7:0]        sync_per;
    logic [11:0]       sync_qual;
    logic              sync_d;
    logic              sync_edge;
    logic [TW-1:0]     ss_tmr;
    logic [TW-1:0]     wait_tmr;
    logic [15:0]       ramp_cnt;
    logic [7:0]        hic_cnt;
    logic              switching;
    logic              cycle_end;
    logic              cycle_start;
    logic              run_ok;
    logic              ss_tmr_done;
    logic              hic_cond;
    logic              hic_trip;
    logic              forced_pulse_width_mode_ok;
    logic              dither_en;
    logic [10:0]       rec_ref;

    assign switching   = state inside {st_ss, st_run, st_rec};
    assign cyc_len     = sync_locked ? sync_per : 8'(PERIOD) + 8'(dither_off);
    assign cycle_end   = cyc_cnt >= cyc_len - 8'h01;
    assign cycle_start = switching && cycle_end && !lso_s;
    assign run_ok      = en_s && uvlo_s && !otp_s && ctrl[`BMS_CTRL_EN];
    assign ss_tmr_done = ss_tmr == TW'(SS2_CYC);
    assign hic_cond    = (state inside {st_run, st_rec}) && ss_tmr_done
                         && v40_s && !dmin_s;
    assign hic_trip    = cycle_start && hic_cond
                         && hic_cnt == 8'(`BMS_HIC_CYCLES - 1);
    assign sync_edge   = sync_s && !sync_d;
    assign forced_pulse_width_mode_ok     = (ctrl[`BMS_CTRL_FORCED_PULSE_WIDTH_MODE] || sync_locked)
                         && (next_state inside {st_run, st_rec});
    assign dither_en   = ctrl[`BMS_CTRL_SPREAD] && !sync_locked && !dmin_s
                         && !smo_s && !(sll_s && !forced_pulse_width_mode_active)
                         && switching;
    assign rec_ref     = {1'b0, vout_code} + {1'b0, vout_code} / `BMS_REF_UP_DIV;

    bms_dither #(
        .W    (LFSR_W),
        .TAP  (`BMS_LFSR_TAP),
        .SPAN (SPAN)
    ) u_dither (
        .clk    (pclk),
        .rst_n  (presetn),
        .step   (cycle_start),
        .en     (dither_en),
        .offset (dither_off)
    );

    // mode sequencing
    always_comb begin
        next_state = state;
        if (!run_ok) begin
            next_state = st_off;
        end else begin
            unique case (state)
                st_off: next_state = st_ss;
                st_ss: begin
                    if (vreg_s || ss_tmr_done) begin
                        next_state = st_run;
                    end
                end
                st_run: begin
                    if (hic_trip) begin
                        next_state = st_hic;
                    end else if (vlow_s) begin
                        next_state = st_rec;
                    end
                end
                st_rec: begin
                    if (hic_trip) begin
                        next_state = st_hic;
                    end else if (ref_code == `BMS_REF_FULL) begin
                        next_state = st_run;
                    end
                end
                st_hic: begin
                    if (wait_tmr == TW'(WAIT_CYC - 1)) begin
                        next_state = st_ss;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= st_off;
        end else begin
            state <= next_state;
        end
    end

    // time since soft start began, saturating at the timeout
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ss_tmr <= '0;
        end else if (next_state == st_ss && state != st_ss) begin
            ss_tmr <= '0;
        end else if (!ss_tmr_done) begin
            ss_tmr <= ss_tmr + TW'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_tmr <= '0;
        end else if (state == st_hic) begin
            wait_tmr <= wait_tmr + TW'(1);
        end else begin
            wait_tmr <= '0;
        end
    end

    // reference: ramp in soft start and recovery
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_code <= 10'h000;
            ramp_cnt <= 16'h0000;
        end else if (next_state == st_ss && state != st_ss) begin
            ref_code <= 10'h000;
            ramp_cnt <= 16'h0000;
        end else if (next_state == st_rec && state == st_run) begin
            ramp_cnt <= 16'h0000;
            if (rec_ref > {1'b0, `BMS_REF_FULL}) begin
                ref_code <= `BMS_REF_FULL;
            end else begin
                ref_code <= rec_ref[9:0];
            end
        end else if (state inside {st_ss, st_rec}) begin
            if (ramp_cnt == 16'(RAMP_DIV - 1)) begin
                ramp_cnt <= 16'h0000;
                if (ref_code != `BMS_REF_FULL) begin
                    ref_code <= ref_code + 10'h001;
                end
            end else begin
                ramp_cnt <= ramp_cnt + 16'h0001;
            end
        end else if (state == st_run) begin
            ref_code <= `BMS_REF_FULL;
        end else begin
            ref_code <= 10'h000;
        end
    end

    // cycles since last cycle start (high-side or boot low-side turn-on)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_cnt <= 8'h00;
        end else if (!switching || cycle_start) begin
            cyc_cnt <= 8'h00;
        end else if (cyc_cnt != 8'hff) begin
            cyc_cnt <= cyc_cnt + 8'h01;
        end
    end

    // gate drive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hs_gate <= 1'b0;
            ls_gate <= 1'b0;
        end else if (!(next_state inside {st_ss, st_run, st_rec})) begin
            hs_gate <= 1'b0;
            ls_gate <= 1'b0;
        end else if (cycle_start) begin
            if (boot_s) begin
                hs_gate <= 1'b0;
                ls_gate <= 1'b1;
            end else begin
                hs_gate <= 1'b1;
                ls_gate <= 1'b0;
            end
        end else if (hs_gate && (cycle_end
                     || (cyc_cnt >= 8'(BLANK) && (hsf_s || hsl_s)))) begin
            hs_gate <= 1'b0;
            ls_gate <= 1'b1;
        end else if (ls_gate && diode_emulation && lsz_s && !lso_s) begin
            ls_gate <= 1'b0;
        end
    end

    // hiccup qualification over consecutive cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hic_cnt <= 8'h00;
        end else if (!hic_cond) begin
            hic_cnt <= 8'h00;
        end else if (cycle_start) begin
            hic_cnt <= hic_cnt + 8'h01;
        end
    end

    // external clock qualification
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_d      <= 1'b0;
            sync_int    <= 8'h00;
            sync_per    <= 8'h00;
            sync_qual   <= 12'h000;
            sync_locked <= 1'b0;
        end else begin
            sync_d <= sync_s;
            if (sync_edge) begin
                sync_int <= 8'h00;
                if (sync_int >= 8'(`BMS_SYNC_MIN_CYC - 1)
                    && sync_int < 8'(`BMS_SYNC_MAX_CYC)) begin
                    sync_per <= sync_int + 8'h01;
                    if (sync_qual == 12'(`BMS_SYNC_QUAL - 1)) begin
                        sync_locked <= 1'b1;
                    end else begin
                        sync_qual <= sync_qual + 12'h001;
                    end
                end else begin
                    sync_qual   <= 12'h000;
                    sync_locked <= 1'b0;
                end
            end else if (sync_int == 8'(`BMS_SYNC_MAX_CYC)) begin
                sync_qual   <= 12'h000;
                sync_locked <= 1'b0;
            end else begin
                sync_int <= sync_int + 8'h01;
            end
        end
    end

    // registered mode outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            forced_pulse_width_mode_active     <= 1'b0;
            diode_emulation <= 1'b1;
            dither_active   <= 1'b0;
            hiccup_active   <= 1'b0;
        end else begin
            forced_pulse_width_mode_active     <= forced_pulse_width_mode_ok;
            diode_emulation <= !forced_pulse_width_mode_ok;
            dither_active   <= dither_en;
            hiccup_active   <= next_state == st_hic;
        end
    end

    // apb slave: answer in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_hit(paddr);
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    `BMS_REG_CTRL:   prdata <= {29'h0000_0000, ctrl};
                    `BMS_REG_STATUS: prdata <= {16'h0000, hic_cnt, 1'b0,
                                                sync_locked, dither_active, state};
                    `BMS_REG_REF:    prdata <= {22'h00_0000, ref_code};
                    `BMS_REG_DITHER: prdata <= {16'h0000, sync_per, 4'h0,
                                                dither_off};
                    default:         prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `BMS_CTRL_RST;
        end else if (psel && penable && pready && pwrite
                     && paddr == `BMS_REG_CTRL) begin
            ctrl <= pwdata[2:0];
        end
    end
endmodule

// file: bench/bms_seq_chk_asserts.sv
// port-level checks for the converter sequencer
`timescale 1ns/100ps
module bms_seq_chk (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       boot_uvlo,
    input wire logic       dropout_minoff,
    input wire logic       slow_min_on,
    input wire logic       vout_below_40,
    input wire logic       hs_gate,
    input wire logic       ls_gate,
    input wire logic [9:0] ref_code,
    input wire logic       dither_active,
    input wire logic       hiccup_active,
    input wire logic       sync_locked
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic hs_q;
    int   hs_cnt;
    int   low_cnt;
    // cycles since high-side turn-on; cycles of qualifying low output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hs_q    <= 1'b0;
            hs_cnt  <= 1000;
            low_cnt <= 0;
        end else begin
            hs_q    <= hs_gate;
            hs_cnt  <= (hs_gate && !hs_q) ? 0 : hs_cnt + (hs_cnt < 1000);
            low_cnt <= (vout_below_40 && !dropout_minoff) ? low_cnt + 1 : 0;
        end
    end
    property p_boot;
        boot_uvlo [*6] |-> !$rose(hs_gate);
    endproperty
    a_boot: assert property (p_boot) else $error("high side on with low boot");
    property p_overlap;
        !(hs_gate && ls_gate);
    endproperty
    a_overlap: assert property (p_overlap) else $error("both switches on");
    property p_period;
        $rose(hs_gate) && !sync_locked |-> hs_cnt >= 48;
    endproperty
    a_period: assert property (p_period) else $error("high side on too soon");
    property p_qual;
        $rose(hiccup_active) |-> low_cnt >= 6200;
    endproperty
    a_qual: assert property (p_qual) else $error("hiccup without qualification");
    property p_hic_off;
        hiccup_active |-> !hs_gate && !ls_gate;
    endproperty
    a_hic_off: assert property (p_hic_off) else $error("switching in hiccup");
    property p_slow;
        (slow_min_on || dropout_minoff) [*5] |-> !dither_active;
    endproperty
    a_slow: assert property (p_slow) else $error("dither on slowed clock");
    property p_lock;
        sync_locked [*3] |-> !dither_active;
    endproperty
    a_lock: assert property (p_lock) else $error("dither while locked");
    property p_ref;
        ref_code <= 10'h3e8;
    endproperty
    a_ref: assert property (p_ref) else $error("reference above full");
    property p_apb;
        psel && penable |-> pready;
    endproperty
    a_apb: assert property (p_apb) else $error("no ready in access cycle");
endmodule

bind bms_sequencer bms_seq_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .boot_uvlo(boot_uvlo),
    .dropout_minoff(dropout_minoff), .slow_min_on(slow_min_on),
    .vout_below_40(vout_below_40), .hs_gate(hs_gate), .ls_gate(ls_gate),
    .ref_code(ref_code), .dither_active(dither_active),
    .hiccup_active(hiccup_active), .sync_locked(sync_locked));

// file: bench/bms_plant.sv
// sense comparators and boot capacitor seen by the sequencer
`timescale 1ns/100ps
module bms_plant (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic hs_gate,
    input  wire logic ls_gate,
    input  wire logic ovl,
    output logic      boot_uvlo,
    output logic      hs_lim_fixed,
    output logic      hs_lim_loop,
    output logic      ls_over_limit,
    output logic      ls_zero_cross
);
    int il;
    int ls_on;
    int idle;
    // inductor current rises with high side, falls with low side
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            il        <= 0;
            ls_on     <= 0;
            idle      <= 0;
            boot_uvlo <= 1'b1;
        end else begin
            il        <= hs_gate ? il + 1 : il - (ls_gate && il > 0);
            ls_on     <= ls_gate ? ls_on + 1 : 0;
            idle      <= (hs_gate || ls_gate) ? 0 : idle + (idle < 300);
            boot_uvlo <= (ls_on >= 3) ? 1'b0 : ((idle >= 200) ? 1'b1 : boot_uvlo);
        end
    end
    assign hs_lim_loop   = il >= 20;
    assign hs_lim_fixed  = il >= 30;
    assign ls_over_limit = ovl && ls_gate && ls_on < 80;
    assign ls_zero_cross = ls_gate && il == 0;
endmodule

// file: bench/tb.sv
// self-checking bench for the converter sequencer
`timescale 1ns/100ps
module tb;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] x; logic e;} bms_row_t;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic        pready, pslverr, er, ovl = 0, sync_en = 0, rst_mm = 0, hs_d = 0;
    logic        en_pin = 0, uvlo_ok = 0, otp_flag = 0, sync_pin = 0, vout_low = 0;
    logic        vout_below_40 = 0, vout_in_reg = 0, dropout_minoff = 0;
    logic        slow_light_load = 0, slow_min_on = 0;
    logic [9:0]  vout_code = 0, ref_code;
    logic        boot_uvlo, hs_lim_fixed, hs_lim_loop, ls_over_limit, ls_zero_cross;
    logic        hs_gate, ls_gate, diode_emulation, forced_pulse_width_mode_active, dither_active;
    logic        hiccup_active, sync_locked;
    logic [1:0]  first_g = 0;
    int          n_mismatch = 0, cmp_count = 0, k, hs_age = 0, hs_per = 0;
    int          hs_min = 999, hs_max = 0, sync_ph = 0;
    // write rows carry data in x and expect only the error flag
    bms_row_t    rows [9] = '{
        '{1'b0, 8'h00, 32'h3, 1'b0}, '{1'b1, 8'h00, 32'h7, 1'b0},
        '{1'b0, 8'h00, 32'h7, 1'b0}, '{1'b0, 8'h04, 32'h1, 1'b0},
        '{1'b1, 8'h04, 32'hffff, 1'b0}, '{1'b0, 8'h04, 32'h1, 1'b0},
        '{1'b0, 8'h08, 32'h0, 1'b0}, '{1'b0, 8'h10, 32'h0, 1'b1},
        '{1'b1, 8'h10, 32'h0, 1'b1}};

    bms_sequencer #(.SS_CYC(2000), .SS2_CYC(3000), .WAIT_CYC(500)) dut_u (.*);
    bms_plant pm_u (.*);

    always #25 pclk = ~pclk;
    // switching period monitor and sync source
    always @(posedge pclk) begin
        hs_d     <= hs_gate;
        sync_ph  <= (sync_ph == 11) ? 0 : sync_ph + 1;
        sync_pin <= sync_en && sync_ph < 6;
        hs_age   <= (hs_gate && !hs_d) ? 1 : hs_age + 1;
        if (first_g == 2'h0 && presetn)
            first_g <= {hs_gate, ls_gate};
        if (hs_gate && !hs_d)
            hs_per <= hs_age;
        if (rst_mm) begin
            hs_min <= 999;
            hs_max <= 0;
        end else if (hs_gate && !hs_d) begin
            hs_min <= (hs_age < hs_min) ? hs_age : hs_min;
            hs_max <= (hs_age > hs_max) ? hs_age : hs_max;
        end
    end

    task automatic conclude();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k == 20) begin
            n_mismatch++;
            conclude();
        end
        @(posedge pclk);
    endtask

    function automatic logic sig(input int i);
        case (i)
            0: return hiccup_active;
            1: return sync_locked;
            2: return !hiccup_active;
            default: return ref_code !== 10'h3e8;
        endcase
    endfunction

    task automatic upto(input int i, input int n);
        for (k = 0; k < n && sig(i) !== 1'b1; k++)
            @(posedge pclk);
        if (k == n) begin
            n_mismatch++;
            conclude();
        end
    endtask

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].x);
            chk(er, rows[i].e);
            if (!rows[i].w)
                chk(rd, rows[i].x);
        end
        en_pin  <= 1'b1;
        uvlo_ok <= 1'b1;
        repeat (10) @(posedge pclk);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd[4:0], 5'h2);
        chk(forced_pulse_width_mode_active, 1'h0);
        chk(diode_emulation, 1'h1);
        repeat (990) @(posedge pclk);
        chk(ref_code > 10'h190 && ref_code < 10'h258, 1'h1);
        repeat (1050) @(posedge pclk);
        chk(ref_code, 10'h3e8);
        chk(forced_pulse_width_mode_active, 1'h0);
        repeat (1000) @(posedge pclk);
        chk(forced_pulse_width_mode_active, 1'h1);
        chk(dither_active, 1'h1);
        chk(first_g, 2'h1);
        rst_mm <= 1'b1;
        @(posedge pclk);
        rst_mm <= 1'b0;
        repeat (3000) @(posedge pclk);
        chk(hs_min >= 49 && hs_max <= 51 && hs_max > hs_min, 1'h1);
        for (int i = 0; i < 3; i++) begin
            {dropout_minoff, slow_min_on, slow_light_load} <= 3'h4 >> i;
            repeat (8) @(posedge pclk);
            chk(dither_active, i == 2);
            {dropout_minoff, slow_min_on, slow_light_load} <= 3'h0;
            repeat (8) @(posedge pclk);
            chk(dither_active, 1'h1);
        end
        ovl <= 1'b1;
        repeat (400) @(posedge pclk);
        chk(hs_per >= 80, 1'h1);
        ovl <= 1'b0;
        apb(1'b1, 8'h00, 32'h3);
        sync_en <= 1'b1;
        repeat (24000) @(posedge pclk);
        chk(sync_locked, 1'h0);
        upto(1, 1200);
        repeat (60) @(posedge pclk);
        chk(dither_active, 1'h0);
        chk(forced_pulse_width_mode_active, 1'h1);
        chk(hs_per, 12);
        sync_en <= 1'b0;
        repeat (150) @(posedge pclk);
        chk(sync_locked, 1'h0);
        apb(1'b1, 8'h00, 32'h7);
        vout_code     <= 10'h12c;
        vout_low      <= 1'b1;
        vout_below_40 <= 1'b1;
        upto(3, 50);
        chk(ref_code >= 10'h12f && ref_code <= 10'h130, 1'h1);
        chk(forced_pulse_width_mode_active, 1'h1);
        repeat (3000) @(posedge pclk);
        chk(hiccup_active, 1'h0);
        vout_below_40 <= 1'b0;
        repeat (120) @(posedge pclk);
        vout_below_40 <= 1'b1;
        upto(0, 7000);
        chk(k >= 6223 && k <= 6540, 1'h1);
        repeat (5) @(posedge pclk);
        chk({hs_gate, ls_gate}, 2'h0);
        vout_low      <= 1'b0;
        vout_below_40 <= 1'b0;
        vout_code     <= 10'h3e8;
        upto(2, 600);
        chk(k >= 485 && k <= 500, 1'h1);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd[4:0], 5'h2);
        chk(diode_emulation, 1'h1);
        vout_in_reg <= 1'b1;
        repeat (5) @(posedge pclk);
        chk(forced_pulse_width_mode_active, 1'h1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({hs_gate, ls_gate, diode_emulation, ref_code}, 13'h0400);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h3);
        conclude();
    end
endmodule
